// ==== bench/dvrx_out_tb.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Bench of the receiver pixel output stage.
// ****************************************************************
module dvrx_out_tb;
	localparam int IDLE = 64;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic pixels_per_clock_select = 1'b0;
	logic stagger_select_n = 1'b1;
	logic output_clock_edge_select = 1'b1;
	logic pd_pin = 1'b1;
	logic tie_pd = 1'b0;
	logic output_driver_powerdown_n;
	dvrx_pkg::dvrx_lane_t link_lane_0;
	dvrx_pkg::dvrx_lane_t link_lane_1;
	dvrx_pkg::dvrx_lane_t link_lane_2;
	logic [23:0] even_pixel_bus;
	logic [23:0] odd_pixel_bus;
	dvrx_pkg::dvrx_ctl_t ctl_out;
	logic output_pixel_clock;
	logic link_active_detect;
	logic pixel_drive_en;
	logic overflow_flag;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int last_rise = 0;
	int ock_per = 0;
	int last_even = 0;
	int lag = 0;
	int r = 0;
	logic two_pix = 1'b0;
	logic prev_ock = 1'b0;
	logic [23:0] prev_even = 24'h0;
	logic [23:0] prev_odd = 24'h0;
	logic [47:0] eq[$];
	logic [47:0] oq[$];
	logic [47:0] exp_e[$];
	logic [47:0] exp_o[$];

	// The board may tie link activity to the driver power-down pin.
	assign output_driver_powerdown_n = tie_pd ? link_active_detect : pd_pin;

	// Core clock, and a link clock of unrelated phase.
	always #5 ref_clk = ~ref_clk;
	initial begin
		#37.3;
		forever #80 link_clk = ~link_clk;
	end

	dvrx_out #(.IDLE_CYC(IDLE), .BUF_DEPTH(2)) dvrx_out_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk),
		.link_lane_0(link_lane_0), .link_lane_1(link_lane_1),
		.link_lane_2(link_lane_2),
		.pixels_per_clock_select(pixels_per_clock_select),
		.stagger_select_n(stagger_select_n),
		.output_clock_edge_select(output_clock_edge_select),
		.output_driver_powerdown_n(output_driver_powerdown_n),
		.even_pixel_bus(even_pixel_bus), .odd_pixel_bus(odd_pixel_bus),
		.ctl_out(ctl_out), .output_pixel_clock(output_pixel_clock),
		.link_active_detect(link_active_detect),
		.pixel_drive_en(pixel_drive_en), .overflow_flag(overflow_flag)
	);

	dvrx_tx_model dvrx_tx_model_i (
		.link_clk(link_clk), .link_lane_0(link_lane_0),
		.link_lane_1(link_lane_1), .link_lane_2(link_lane_2)
	);

	// ****************************************************************
	// Checking helpers.
	// ****************************************************************
	// Compares one value and counts the outcome.
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Compares a captured sequence with the expected one.
	task automatic cmp_q(ref logic [47:0] got[$], ref logic [47:0] exp[$]);
		check(48'(got.size()), 48'(exp.size()));
		for (int i = 0; i < exp.size() && i < got.size(); i++) begin
			check(got[i], exp[i]);
		end
	endtask : cmp_q

	// Expected bus word of active pixel k.
	function automatic logic [23:0] rgb(input logic [7:0] k);
		rgb = {k + 8'h40, k ^ 8'h3c, k};
	endfunction : rgb

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up

	// Records bus changes, output clock period and odd bus offset.
	always @(negedge ref_clk) begin
		cyc++;
		if (output_pixel_clock === 1'b1 && prev_ock === 1'b0) begin
			ock_per = cyc - last_rise;
			last_rise = cyc;
		end
		if (even_pixel_bus !== prev_even) begin
			eq.push_back({18'h0, ctl_out, even_pixel_bus});
			last_even = cyc;
			check(output_pixel_clock, !output_clock_edge_select);
		end
		if (odd_pixel_bus !== prev_odd) begin
			oq.push_back({24'h0, odd_pixel_bus});
			if (two_pix) begin
				check(48'(cyc - last_even), 48'(lag));
			end else begin
				check(odd_pixel_bus, 24'h0);
			end
		end
		prev_ock = output_pixel_clock;
		prev_even = even_pixel_bus;
		prev_odd = odd_pixel_bus;
	end

	// ****************************************************************
	// Stimulus tasks.
	// ****************************************************************
	// Sets the mode pins in blanking and checks the output period.
	task automatic set_mode(input logic two, input logic stagger_select_n_n,
		input logic edge_sel);
		@(posedge ref_clk);
		#1;
		pixels_per_clock_select = two;
		stagger_select_n = stagger_select_n_n;
		output_clock_edge_select = edge_sel;
		two_pix = two;
		lag = (two && !stagger_select_n_n) ? 16 : 0;
		repeat (100) @(posedge ref_clk);
		check(48'(ock_per), two ? 48'h20 : 48'h10);
	endtask : set_mode

	// Sends blank, n active pixels from base, blank, and compares buses.
	task automatic run_line(input int n, input logic [7:0] base);
		logic [7:0] k;
		eq.delete();
		oq.delete();
		exp_e.delete();
		exp_o.delete();
		for (int i = 0; i < 5; i++) dvrx_tx_model_i.send(1'b0, 8'(i));
		for (int i = 0; i < n; i++) begin
			k = base + 8'(i);
			dvrx_tx_model_i.send(1'b1, k);
			if (two_pix && i[0]) exp_o.push_back({24'h0, rgb(k)});
			else exp_e.push_back({18'h0, 6'h2d, rgb(k)});
		end
		for (int i = 0; i < 6; i++) dvrx_tx_model_i.send(1'b0, 8'(i));
		exp_e.push_back({18'h0, 6'h25, 24'h0});
		if (two_pix) exp_o.push_back(48'h0);
		repeat (120) @(posedge ref_clk);
		cmp_q(eq, exp_e);
		cmp_q(oq, exp_o);
	endtask : run_line

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial begin
		repeat (2) @(posedge link_clk);
		check({even_pixel_bus, odd_pixel_bus}, 48'h0);
		check({link_active_detect, pixel_drive_en}, 2'h0);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge link_clk);
		check(pixel_drive_en, 1'b1);
		$display("test reset done");
		set_mode(1'b0, 1'b0, 1'b1);
		run_line(8, 8'h10);
		$display("test one pixel done");
		set_mode(1'b1, 1'b1, 1'b1);
		run_line(8, 8'h30);
		$display("test two pixel done");
		set_mode(1'b1, 1'b0, 1'b0);
		run_line(8, 8'h50);
		$display("test stagger done");
		set_mode(1'b0, 1'b1, 1'b1);
		@(posedge ref_clk);
		#1;
		tie_pd = 1'b1;
		for (int i = 0; i < 12; i++) dvrx_tx_model_i.send(i[1], 8'(i));
		check(link_active_detect, 1'b1);
		check(pixel_drive_en, 1'b1);
		for (int i = 0; i < 20; i++) dvrx_tx_model_i.send(1'b0, 8'(i));
		check(link_active_detect, 1'b0);
		check(pixel_drive_en, 1'b0);
		$display("test link activity done");
		check(overflow_flag, 1'b0);
		@(posedge ref_clk);
		#1;
		ce = 1'b0;
		// A rise launched just before the freeze is seen at the next negedge.
		@(posedge ref_clk);
		r = last_rise;
		repeat (80) @(posedge ref_clk);
		check(48'(last_rise), 48'(r));
		#1;
		ce = 1'b1;
		$display("test clock enable done");
		wrap_up();
	end

	// Cuts a hang short well after the tests should have ended.
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end
endmodule : dvrx_out_tb

// ==== bench/dvrx_tx_model.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Link transmitter model: one decoded pixel per link clock.
// ****************************************************************
module dvrx_tx_model (
	input wire logic link_clk, // Link pixel clock.
	output dvrx_pkg::dvrx_lane_t link_lane_0, // Blue and sync lane.
	output dvrx_pkg::dvrx_lane_t link_lane_1, // Green and control lane.
	output dvrx_pkg::dvrx_lane_t link_lane_2 // Red and control lane.
);
	// Blank codes: horizontal sync, first and third control high.
	localparam logic [1:0] C0 = 2'h1;
	localparam logic [1:0] C1 = 2'h1;
	localparam logic [1:0] C2 = 2'h2;

	// Drives one pixel after a link edge; blank colour bytes and active
	// control codes carry junk that the receiver has to ignore.
	task automatic send(input logic de, input logic [7:0] k);
		@(posedge link_clk);
		#1;
		link_lane_0 = '{de, de ? ~C0 : C0, de ? k : 8'ha5 ^ k};
		link_lane_1 = '{de, de ? ~C1 : C1, de ? k ^ 8'h3c : 8'h5a};
		link_lane_2 = '{de, de ? ~C2 : C2, de ? k + 8'h40 : ~k};
	endtask : send

	// The link starts in blanking.
	initial begin
		link_lane_0 = '{1'b0, C0, 8'h00};
		link_lane_1 = '{1'b0, C1, 8'h00};
		link_lane_2 = '{1'b0, C2, 8'h00};
	end
endmodule : dvrx_tx_model

// ==== pkg/dvrx_pkg.sv ====
// ****************************************************************
// Shared constants and types of the receiver pixel output stage.
// ****************************************************************
package dvrx_pkg;
	// Colour byte lanes of a 24-bit pixel bus.
	localparam int COL_W = 8;
	localparam int PIX_W = 24;
	localparam int BLUE_LSB = 0;
	localparam int GREEN_LSB = 8;
	localparam int RED_LSB = 16;

	// Core clock rate and link pixel time.
	localparam int REF_MHZ = 100;
	localparam int LINK_PIX_NS = 160;
	localparam int PIX_CYC = (LINK_PIX_NS * REF_MHZ) / 1000;

	// Time without data enable switching before the link is idle.
	localparam int LINK_IDLE_NS = 20000;
	localparam int IDLE_CYC = (LINK_IDLE_NS * REF_MHZ) / 1000;
	localparam int IDLE_W = 12;

	// Output clock periods in core cycles for each pixel mode.
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] PER_ONE = CNT_W'(PIX_CYC);
	localparam logic [CNT_W-1:0] PER_TWO = CNT_W'(2 * PIX_CYC);

	// One decoded link lane: enable, two blank codes and a colour byte.
	typedef struct packed {
		logic de;
		logic [1:0] ctl;
		logic [COL_W-1:0] data;
	} dvrx_lane_t;

	// Sync and control values that travel with each pixel.
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic de;
		logic ctl1;
		logic ctl2;
		logic ctl3;
	} dvrx_ctl_t;

	typedef struct packed {
		dvrx_ctl_t ctl;
		logic [PIX_W-1:0] rgb;
	} dvrx_pix_t;

	typedef struct packed {
		dvrx_pix_t odd;
		dvrx_pix_t even;
	} dvrx_pair_t;

	// Which pixel of a pair comes next.
	typedef enum logic {DVRX_EVEN, DVRX_ODD} dvrx_phase_t;

	// Packs three colour bytes with blue lowest and red highest.
	function automatic logic [PIX_W-1:0] dvrx_rgb(
		input logic [COL_W-1:0] b,
		input logic [COL_W-1:0] g,
		input logic [COL_W-1:0] r);
		dvrx_rgb = {r, g, b};
	endfunction : dvrx_rgb
endpackage : dvrx_pkg

// ==== rtl/dvrx_buf.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Small word buffer with valid and ready on both sides.
// ****************************************************************
module dvrx_buf #(
	parameter int W = 60, // Word width.
	parameter int DEPTH = 2 // Number of entries.
) (
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic en, // Clock enable.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [W-1:0] in_data, // Offered word.
	output logic out_valid, // Head word present.
	input wire logic out_ready, // Head word taken.
	output logic [W-1:0] out_data // Head word.
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Honest full and empty flags from the fill count.
	assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];

	// Pointer and count updates.
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = push ? ((wp_r == LAST) ? '0 : wp_r + 1'b1) : wp_r;
		rp_nxt = pop ? ((rp_r == LAST) ? '0 : rp_r + 1'b1) : rp_r;
		cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	// Storage and pointers, frozen while the enable is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (en) begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			if (push) begin
				mem_r[wp_r] <= in_data;
			end
		end
	end
endmodule : dvrx_buf

// ==== rtl/dvrx_out.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - One-pixel mode puts even then odd pixels on the even bus.
// - Two-pixel mode carries only even pixels on the even bus.
// - Two-pixel mode carries only odd pixels on the odd bus.
// - One-pixel mode holds the odd bus at all zeros.
// - Pixel buses change on the output clock launch edge, a staggered odd bus on the opposite edge.
// - Bus bytes: blue 7:0, green 15:8, red 23:16.
// - Lane 0 gives blue when active, horizontal and vertical sync in blank.
// - Lane 1 gives green when active, first control value in blank.
// - Lane 2 gives red when active, second and third control in blank.
// - Link active output high while data enable switches, else low.
// - Two-pixel mode with stagger low offsets odd bus from even bus.
// - Stagger select has no effect in one-pixel mode.
// - Pixel mode select high picks two pixels, low picks one.
// - Even pixel goes first; pixel zero of a line is even.
// - Output period is one pixel time, or two in two-pixel mode.
// - Edge select high: latch on rising output clock edge, low: falling.
module dvrx_out #(
	parameter int IDLE_CYC = dvrx_pkg::IDLE_CYC, // Idle time in cycles.
	parameter int BUF_DEPTH = 2 // Entries of the pair buffer.
) (
	input wire logic ref_clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic ce, // Clock enable; low freezes all state except the enable synchroniser, link side after its two stages.
	input wire logic link_clk, // Recovered link pixel clock.
	input wire dvrx_pkg::dvrx_lane_t link_lane_0, // Decoded lane 0.
	input wire dvrx_pkg::dvrx_lane_t link_lane_1, // Decoded lane 1.
	input wire dvrx_pkg::dvrx_lane_t link_lane_2, // Decoded lane 2.
	input wire logic pixels_per_clock_select, // High: two pixels a clock.
	input wire logic stagger_select_n, // Low: stagger the odd bus.
	input wire logic output_clock_edge_select, // High: rising edge latch.
	input wire logic output_driver_powerdown_n, // Low: drivers off.
	output logic [23:0] even_pixel_bus, // Even pixel bus.
	output logic [23:0] odd_pixel_bus, // Odd pixel bus.
	output dvrx_pkg::dvrx_ctl_t ctl_out, // Controls of the even bus pixel.
	output logic output_pixel_clock, // Generated output clock.
	output logic link_active_detect, // High while the link is active.
	output logic pixel_drive_en, // High while pixel drivers are on.
	output logic overflow_flag // Sticky: a pair word was lost.
);
	localparam logic [dvrx_pkg::IDLE_W-1:0] IDLE_LAST =
		dvrx_pkg::IDLE_W'(IDLE_CYC - 1);
	localparam int PW = $bits(dvrx_pkg::dvrx_pair_t);

	// ************************************************************
	// Link side: lane recovery and pixel pairing.
	// ************************************************************
	logic ce_l;
	dvrx_pkg::dvrx_ctl_t held_r, held_nxt;
	dvrx_pkg::dvrx_pix_t cur_pix, hold_r, hold_nxt;
	dvrx_pkg::dvrx_pair_t pair_r, pair_nxt;
	dvrx_pkg::dvrx_phase_t phase_r, phase_nxt;
	logic prev_de_r, prev_de_nxt, tog_r, tog_nxt, is_even;

	// The core clock enable reaches the link logic through a synchroniser.
	dvrx_sync #(.W(1)) u_ce_sync (
		.clk(link_clk),
		.rst_n(rst_n),
		.en(1'b1),
		.d(ce),
		.q(ce_l)
	);

	// Blank codes are held through active video; a DE edge restarts pairing.
	always_comb begin
		held_nxt = held_r;
		held_nxt.de = link_lane_0.de;
		if (!link_lane_0.de) begin
			held_nxt.hsync = link_lane_0.ctl[0];
			held_nxt.vsync = link_lane_0.ctl[1];
			held_nxt.ctl1 = link_lane_1.ctl[0];
			held_nxt.ctl2 = link_lane_2.ctl[0];
			held_nxt.ctl3 = link_lane_2.ctl[1];
		end
		cur_pix.ctl = held_nxt;
		cur_pix.rgb = '0;
		if (link_lane_0.de) begin
			cur_pix.rgb = dvrx_pkg::dvrx_rgb(link_lane_0.data,
				link_lane_1.data, link_lane_2.data);
		end
		is_even = (phase_r == dvrx_pkg::DVRX_EVEN) ||
			(link_lane_0.de != prev_de_r);
		prev_de_nxt = link_lane_0.de;
		hold_nxt = hold_r;
		pair_nxt = pair_r;
		tog_nxt = tog_r;
		if (is_even) begin
			hold_nxt = cur_pix;
			phase_nxt = dvrx_pkg::DVRX_ODD;
		end else begin
			pair_nxt.even = hold_r;
			pair_nxt.odd = cur_pix;
			tog_nxt = !tog_r;
			phase_nxt = dvrx_pkg::DVRX_EVEN;
		end
	end

	// A pair word stays stable for two link cycles after its toggle.
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			held_r <= '0;
			hold_r <= '0;
			pair_r <= '0;
			phase_r <= dvrx_pkg::DVRX_EVEN;
			prev_de_r <= 1'b0;
			tog_r <= 1'b0;
		end else if (ce_l) begin
			held_r <= held_nxt;
			hold_r <= hold_nxt;
			pair_r <= pair_nxt;
			phase_r <= phase_nxt;
			prev_de_r <= prev_de_nxt;
			tog_r <= tog_nxt;
		end
	end

	// ************************************************************
	// Core side: crossing, buffering and output timing.
	// ************************************************************
	logic [4:0] pin_q;
	logic tog_s, pps_s, stagger_select_n_s, edge_s, pdo_s, new_evt, tgl;
	logic seen_r, pend_v_r, pend_v_nxt, ovf_nxt, buf_rdy, buf_vld, pop;
	dvrx_pkg::dvrx_pair_t pend_r, pend_nxt, head;
	logic [dvrx_pkg::CNT_W-1:0] cnt_r, cnt_nxt, per, half;
	logic base_r, base_nxt, ock_nxt, last_de_r, last_de_nxt, act_nxt;
	dvrx_pkg::dvrx_phase_t slot_r, slot_nxt;
	logic [23:0] even_nxt, odd_nxt, stage_r, stage_nxt;
	dvrx_pkg::dvrx_ctl_t ctl_nxt;
	logic [dvrx_pkg::IDLE_W-1:0] idle_r, idle_nxt;

	// Pins and the link toggle pass two flip-flops before use.
	dvrx_sync #(.W(5)) u_pin_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.en(ce),
		.d({tog_r, pixels_per_clock_select, stagger_select_n,
			output_clock_edge_select, output_driver_powerdown_n}),
		.q(pin_q)
	);
	assign {tog_s, pps_s, stagger_select_n_s, edge_s, pdo_s} = pin_q;

	// Buffer of BUF_DEPTH entries between the crossing and the output stage.
	dvrx_buf #(.W(PW), .DEPTH(BUF_DEPTH)) u_buf (
		.clk(ref_clk),
		.rst_n(rst_n),
		.en(ce),
		.in_valid(pend_v_r),
		.in_ready(buf_rdy),
		.in_data(pend_r),
		.out_valid(buf_vld),
		.out_ready(pop),
		.out_data(head)
	);

	// Capture a crossed pair; a stalled buffer holds it pending.
	always_comb begin
		new_evt = (tog_s != seen_r);
		pend_nxt = pend_r;
		pend_v_nxt = pend_v_r && !buf_rdy;
		ovf_nxt = overflow_flag;
		if (new_evt) begin
			if (pend_v_nxt) begin
				ovf_nxt = 1'b1;
			end else begin
				pend_nxt = pair_r;
				pend_v_nxt = 1'b1;
			end
		end
	end

	// Output clock, pixel launch and link activity.
	always_comb begin
		per = pps_s ? dvrx_pkg::PER_TWO : dvrx_pkg::PER_ONE;
		half = per >> 1;
		cnt_nxt = (cnt_r >= per - 1'b1) ? '0 : cnt_r + 1'b1;
		base_nxt = (cnt_nxt >= half);
		ock_nxt = base_nxt ^ !edge_s;
		pop = 1'b0;
		even_nxt = even_pixel_bus;
		odd_nxt = odd_pixel_bus;
		stage_nxt = stage_r;
		ctl_nxt = ctl_out;
		slot_nxt = pps_s ? dvrx_pkg::DVRX_EVEN : slot_r;
		if (cnt_nxt == '0 && buf_vld) begin
			if (pps_s) begin
				pop = 1'b1;
				even_nxt = head.even.rgb;
				ctl_nxt = head.even.ctl;
				if (stagger_select_n_s) begin
					odd_nxt = head.odd.rgb;
				end else begin
					stage_nxt = head.odd.rgb;
				end
			end else begin
				case (slot_r)
					dvrx_pkg::DVRX_EVEN: begin
						even_nxt = head.even.rgb;
						ctl_nxt = head.even.ctl;
						slot_nxt = dvrx_pkg::DVRX_ODD;
					end
					dvrx_pkg::DVRX_ODD: begin
						even_nxt = head.odd.rgb;
						ctl_nxt = head.odd.ctl;
						pop = 1'b1;
						slot_nxt = dvrx_pkg::DVRX_EVEN;
					end
					default: begin
						slot_nxt = dvrx_pkg::DVRX_EVEN;
					end
				endcase
			end
		end
		if (pps_s && !stagger_select_n_s && cnt_nxt == half) begin
			odd_nxt = stage_r;
		end
		if (!pps_s) begin
			odd_nxt = '0;
		end
		tgl = (pair_r.even.ctl.de != last_de_r) ||
			(pair_r.odd.ctl.de != pair_r.even.ctl.de);
		last_de_nxt = new_evt ? pair_r.odd.ctl.de : last_de_r;
		idle_nxt = idle_r;
		act_nxt = link_active_detect;
		if (new_evt && tgl) begin
			idle_nxt = '0;
			act_nxt = 1'b1;
		end else if (idle_r != IDLE_LAST) begin
			idle_nxt = idle_r + 1'b1;
		end else begin
			act_nxt = 1'b0;
		end
	end

	// Every output comes from one of these flip-flops.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_r <= 1'b0;
			pend_r <= '0;
			pend_v_r <= 1'b0;
			overflow_flag <= 1'b0;
			cnt_r <= '0;
			base_r <= 1'b0;
			output_pixel_clock <= 1'b0;
			slot_r <= dvrx_pkg::DVRX_EVEN;
			even_pixel_bus <= '0;
			odd_pixel_bus <= '0;
			stage_r <= '0;
			ctl_out <= '0;
			last_de_r <= 1'b0;
			idle_r <= '0;
			link_active_detect <= 1'b0;
			pixel_drive_en <= 1'b0;
		end else if (ce) begin
			seen_r <= tog_s;
			pend_r <= pend_nxt;
			pend_v_r <= pend_v_nxt;
			overflow_flag <= ovf_nxt;
			cnt_r <= cnt_nxt;
			base_r <= base_nxt;
			output_pixel_clock <= ock_nxt;
			slot_r <= slot_nxt;
			even_pixel_bus <= even_nxt;
			odd_pixel_bus <= odd_nxt;
			stage_r <= stage_nxt;
			ctl_out <= ctl_nxt;
			last_de_r <= last_de_nxt;
			idle_r <= idle_nxt;
			link_active_detect <= act_nxt;
			pixel_drive_en <= pdo_s;
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	logic [dvrx_pkg::CNT_W-1:0] a_gap_r;
	logic a_stable_r, a_mode_r;

	// Counts core cycles between base clock rises in a steady mode.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_gap_r <= '0;
			a_stable_r <= 1'b0;
			a_mode_r <= 1'b0;
		end else if (ce) begin
			a_mode_r <= pps_s;
			if (base_nxt && !base_r) begin
				a_gap_r <= dvrx_pkg::CNT_W'(1);
				// A rise in the cycle of a mode change starts no clean period.
				a_stable_r <= (pps_s == a_mode_r);
			end else begin
				a_gap_r <= a_gap_r + 1'b1;
				if (pps_s != a_mode_r) begin
					a_stable_r <= 1'b0;
				end
			end
		end
	end

	property p_odd_low;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && !pps_s) |=> (odd_pixel_bus == '0);
	endproperty
	a_odd_low: assert property (p_odd_low) else $error("odd bus not low");

	property p_two_even;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && pps_s && cnt_nxt == '0 && buf_vld) |=>
			(even_pixel_bus == $past(head.even.rgb));
	endproperty
	a_two_even: assert property (p_two_even) else $error("even bus bad");

	property p_two_odd;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && pps_s && stagger_select_n_s && cnt_nxt == '0 && buf_vld) |=>
			(odd_pixel_bus == $past(head.odd.rgb));
	endproperty
	a_two_odd: assert property (p_two_odd) else $error("odd bus bad");

	property p_stagger;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && pps_s && !stagger_select_n_s && cnt_nxt == '0 && buf_vld) |=>
			(odd_pixel_bus == $past(odd_pixel_bus)) &&
			(stage_r == $past(head.odd.rgb));
	endproperty
	a_stagger: assert property (p_stagger) else $error("no stagger");

	property p_one_seq;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && !pps_s && cnt_nxt == '0 && buf_vld &&
			slot_r == dvrx_pkg::DVRX_ODD)
			|=> (even_pixel_bus == $past(head.odd.rgb)) && !$past(pop) == 1'b0;
	endproperty
	a_one_seq: assert property (p_one_seq) else $error("odd slot bad");

	property p_period;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && base_nxt && !base_r && a_stable_r && pps_s == a_mode_r) |->
			(a_gap_r == (pps_s ? dvrx_pkg::PER_TWO : dvrx_pkg::PER_ONE));
	endproperty
	a_period: assert property (p_period) else $error("clock period bad");

	property p_edge;
		@(posedge ref_clk) disable iff (!rst_n)
		($changed(even_pixel_bus) && $stable(edge_s)) |->
			(output_pixel_clock == !edge_s);
	endproperty
	a_edge: assert property (p_edge) else $error("launch edge bad");

	property p_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		(ce && idle_r == IDLE_LAST && !(new_evt && tgl)) |=>
			!link_active_detect;
	endproperty
	a_idle: assert property (p_idle) else $error("link still active");

	property p_recover;
		@(posedge link_clk) disable iff (!rst_n)
		(ce_l && is_even && !link_lane_0.de) |=>
			(hold_r.ctl.hsync == $past(link_lane_0.ctl[0])) &&
			(hold_r.ctl.ctl1 == $past(link_lane_1.ctl[0])) &&
			(hold_r.ctl.ctl3 == $past(link_lane_2.ctl[1]));
	endproperty
	a_recover: assert property (p_recover) else $error("blank codes bad");

	property p_first_even;
		@(posedge link_clk) disable iff (!rst_n)
		(ce_l && link_lane_0.de && !prev_de_r) |=>
			(phase_r == dvrx_pkg::DVRX_ODD) &&
			(hold_r.rgb[7:0] == $past(link_lane_0.data));
	endproperty
	a_first_even: assert property (p_first_even) else $error("pixel 0 odd");

	c_stagger_select_n: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ce && pps_s && !stagger_select_n_s && cnt_nxt == half);
	c_one_odd: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ce && !pps_s && pop);
	c_idle: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(link_active_detect));
endmodule : dvrx_out

// ==== rtl/dvrx_sync.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Two-stage synchroniser for levels from another clock domain.
// ****************************************************************
module dvrx_sync #(
	parameter int W = 1 // Number of bits.
) (
	input wire logic clk, // Destination clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic en, // Clock enable.
	input wire logic [W-1:0] d, // Asynchronous input.
	output logic [W-1:0] q // Synchronised output.
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] q_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		s1_nxt = d;
		q_nxt = s1_r;
	end

	// Both stages hold while the enable is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			q <= '0;
		end else if (en) begin
			s1_r <= s1_nxt;
			q <= q_nxt;
		end
	end
endmodule : dvrx_sync
